// ---- pkg/adcsc_pkg.sv ----
// Constants, types and states of the converter serial control block
package adcsc_pkg;
    // Word widths and result buffer depth
    localparam int CMD_W      = 8;
    localparam int RES_W      = 10;
    localparam int OUT_BITS   = 12;
    localparam int FIFO_DEPTH = 16;
    // Command bit counts at which the sampler changes
    localparam logic [3:0] TRACK_BIT_NUM = 4'h5;
    localparam logic [3:0] HOLD_BIT_NUM  = 4'h8;
    // Decisions already out before a new start bit is accepted
    localparam logic [3:0] RESTART_BITS  = 4'h3;
    // Clock and power mode codes
    localparam logic [1:0] MODE_PDOWN = 2'h0;
    localparam logic [1:0] MODE_UNASG = 2'h1;
    localparam logic [1:0] MODE_INT   = 2'h2;
    localparam logic [1:0] MODE_EXT   = 2'h3;
    // Reset and conversion start values
    localparam logic [7:0] CMD_RST    = 8'h02;
    localparam logic [9:0] SAR_FIRST  = 10'h200;
    localparam logic [3:0] MSB_IDX    = 4'h9;
    // Internal conversion clock, a longest period rounded down
    localparam int CLK_MHZ      = 125;
    localparam int INT_CLK_KHZ  = 1800;
    localparam int INT_STEP_CYC = (CLK_MHZ * 1000) / INT_CLK_KHZ;

    // Command word fields, start marker at the top
    typedef struct packed {
        logic       start;
        logic [2:0] chan_pick;
        logic       polarity_select;
        logic       input_config_select;
        logic [1:0] clk_power_mode;
    } adcsc_cmd_t;

    // Sampling node connections
    typedef struct packed {
        logic [3:0] pos;
        logic [3:0] neg;
        logic       common_ref_input;
    } adcsc_mux_t;

    typedef enum logic [2:0] {
        ST_IDLE     = 3'h0,
        ST_EXT_STRB = 3'h1,
        ST_EXT_CONV = 3'h2,
        ST_INT_CONV = 3'h3,
        ST_INT_PUSH = 3'h4
    } adcsc_state_t;
endpackage

// ---- design/adcsc_fifo.sv ----
// Result FIFO with valid and ready on both sides
`timescale 1ns/100ps
module adcsc_fifo #(
    parameter int WIDTH = 10,
    parameter int DEPTH = 16
) (
    // Clock and reset
    input  wire logic             clk_in,
    input  wire logic             rst_in,
    // Fill side
    input  wire logic             in_valid_in,
    input  wire logic [WIDTH-1:0] in_data_in,
    output logic                  in_ready_out,
    // Drain side
    output logic                  out_valid_out,
    output logic [WIDTH-1:0]      out_data_out,
    input  wire logic             out_ready_in
);
    localparam int AW = $clog2(DEPTH);

    logic [WIDTH-1:0] mem_r [DEPTH];
    logic [AW-1:0]    wr_r;
    logic [AW-1:0]    rd_r;
    logic [AW:0]      cnt_r;
    logic             push;
    logic             pop;

    // Honest full and empty from the fill count
    assign in_ready_out  = (cnt_r < (AW+1)'(DEPTH));
    assign out_valid_out = (cnt_r != '0);
    assign out_data_out  = mem_r[rd_r];
    assign push          = in_valid_in && in_ready_out;
    assign pop           = out_valid_out && out_ready_in;

    // Storage has no reset; only the pointers matter
    always_ff @(posedge clk_in) begin
        if (push) begin
            mem_r[wr_r] <= in_data_in;
        end
    end

    // Pointers and count
    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            wr_r  <= '0;
            rd_r  <= '0;
            cnt_r <= '0;
        end else begin
            if (push) begin
                wr_r <= wr_r + 1'b1;
            end
            if (pop) begin
                rd_r <= rd_r + 1'b1;
            end
            cnt_r <= cnt_r + (AW+1)'(push) - (AW+1)'(pop);
        end
    end
endmodule

// ---- design/adcsc_top.sv ----
// Serial command, sampling sequence and result logic of the converter
`timescale 1ns/100ps
module adcsc_top (
    // Clock and reset
    input  wire logic                    clk_in,
    input  wire logic                    rst_in,
    // Serial pins
    input  wire logic                    sclk_in,
    input  wire logic                    cs_n_in,
    input  wire logic                    din_in,
    output logic                         dout_out,
    output logic                         dout_oe_n_out,
    output logic                         conversion_strobe_out,
    output logic                         conversion_strobe_oe_n_out,
    // Analog front end
    input  wire logic                    comp_in,
    output logic [9:0]                   dac_code_out,
    output adcsc_pkg::adcsc_mux_t        mux_out,
    output logic                         track_out,
    output logic                         unipolar_out,
    output logic                         power_down_out
);
    adcsc_pkg::adcsc_state_t state_r;
    adcsc_pkg::adcsc_cmd_t   cmd_r;
    adcsc_pkg::adcsc_cmd_t   rx_cmd;
    logic [2:0] pin_raw;
    logic [2:0] p0_r, p1_r, p2_r, filt_r;
    logic       sclk_rise, sclk_fall, cs_act, cs_rise, din_s;
    logic [3:0] rx_cnt_r;
    logic [7:0] rx_sh_r;
    logic       rx_en, restart_r, hold_ev;
    logic [9:0] sar_r, sar_nxt;
    logic [3:0] idx_r, step_cnt_r;
    logic       dec, dec_out, step_ev, conv_done;
    logic [6:0] div_r;
    logic       int_step;
    logic       strb_r, track_r, dout_r;
    adcsc_pkg::adcsc_mux_t mux_r;
    logic [11:0] sh_r;
    logic [3:0]  sh_cnt_r;
    logic [9:0]  res;
    logic        fifo_in_ready, fifo_out_valid, pop;
    logic [9:0]  fifo_out_data;

    // All checks below share the system clock and the reset
    default clocking cb @(posedge clk_in); endclocking
    default disable iff (rst_in);

    // Channel decode; unsupported codes connect nothing
    function automatic adcsc_pkg::adcsc_mux_t chan_map(
        input logic [2:0] sel, input logic single);
        adcsc_pkg::adcsc_mux_t m;
        m = '0;
        m.common_ref_input = single;
        unique case (sel)
            3'h1: begin
                m.pos = 4'h1;
                m.neg = single ? 4'h0 : 4'h2;
            end
            3'h5: begin
                m.pos = 4'h2;
                m.neg = single ? 4'h0 : 4'h1;
            end
            3'h2: begin
                m.pos = 4'h4;
                m.neg = single ? 4'h0 : 4'h8;
            end
            3'h6: begin
                m.pos = 4'h8;
                m.neg = single ? 4'h0 : 4'h4;
            end
            default: m.common_ref_input = 1'b0;
        endcase
        return m;
    endfunction

    ////////////////////////////////////////////////////////////////////
    // Pin synchronisers: three stages, change taken when stages agree
    assign pin_raw = {din_in, cs_n_in, sclk_in};
    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            p0_r   <= 3'h2;
            p1_r   <= 3'h2;
            p2_r   <= 3'h2;
            filt_r <= 3'h2;
        end else begin
            p0_r <= pin_raw;
            p1_r <= p0_r;
            p2_r <= p1_r;
            for (int i = 0; i < 3; i++) begin
                if (p1_r[i] == p2_r[i]) begin
                    filt_r[i] <= p2_r[i];
                end
            end
        end
    end
    // Edges of the filtered levels; only stages two and three are read
    assign sclk_rise = (p1_r[0] == p2_r[0]) && p2_r[0] && !filt_r[0];
    assign sclk_fall = (p1_r[0] == p2_r[0]) && !p2_r[0] && filt_r[0];
    assign cs_rise   = (p1_r[1] == p2_r[1]) && p2_r[1] && !filt_r[1];
    assign cs_act    = !filt_r[1];
    assign din_s     = p2_r[2];

    ////////////////////////////////////////////////////////////////////
    // Command receiver
    assign rx_en   = (state_r == adcsc_pkg::ST_IDLE) || restart_r ||
                     (state_r == adcsc_pkg::ST_INT_PUSH) ||
                     (state_r == adcsc_pkg::ST_EXT_CONV &&
                      step_cnt_r >= adcsc_pkg::RESTART_BITS);
    assign hold_ev = sclk_fall && cs_act &&
                     rx_cnt_r == adcsc_pkg::HOLD_BIT_NUM;
    assign rx_cmd  = adcsc_pkg::adcsc_cmd_t'(rx_sh_r);

    // Shift on rising edges; a partial word dies with the frame
    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            rx_cnt_r <= 4'h0;
            rx_sh_r  <= 8'h00;
        end else if (!cs_act) begin
            rx_cnt_r <= 4'h0;
        end else if (hold_ev) begin
            rx_cnt_r <= 4'h0;
        end else if (sclk_rise && rx_cnt_r == 4'h0) begin
            if (din_s && rx_en) begin
                rx_sh_r  <= 8'h01;
                rx_cnt_r <= 4'h1;
            end
        end else if (sclk_rise &&
                     rx_cnt_r < adcsc_pkg::HOLD_BIT_NUM) begin
            rx_sh_r  <= {rx_sh_r[6:0], din_s};
            rx_cnt_r <= rx_cnt_r + 4'h1;
        end
    end

    // A toggled select lets a new word end a running conversion
    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            restart_r <= 1'b0;
        end else if (cs_rise && state_r != adcsc_pkg::ST_IDLE) begin
            restart_r <= 1'b1;
        end else if (hold_ev || state_r == adcsc_pkg::ST_IDLE) begin
            restart_r <= 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Successive approximation step
    assign dec     = (idx_r <= adcsc_pkg::MSB_IDX) && comp_in;
    // Bipolar output is two's complement: the first decision inverts
    assign dec_out = (step_cnt_r == 4'h0 && !cmd_r.polarity_select) ?
                     !dec : dec;
    assign int_step = div_r == 7'(adcsc_pkg::INT_STEP_CYC - 1);
    assign step_ev  = ((state_r == adcsc_pkg::ST_EXT_STRB ||
                        state_r == adcsc_pkg::ST_EXT_CONV) &&
                       sclk_fall && cs_act) ||
                      (state_r == adcsc_pkg::ST_INT_CONV && int_step);
    assign res      = cmd_r.polarity_select ? sar_r :
                      {!sar_r[9], sar_r[8:0]};
    assign conv_done = (state_r == adcsc_pkg::ST_EXT_CONV && step_ev &&
                        step_cnt_r == 4'(adcsc_pkg::OUT_BITS - 1)) ||
                       (state_r == adcsc_pkg::ST_INT_PUSH &&
                        fifo_in_ready);

    always_comb begin
        sar_nxt = sar_r;
        if (idx_r <= adcsc_pkg::MSB_IDX) begin
            sar_nxt[idx_r] = comp_in;
            if (idx_r != 4'h0) begin
                sar_nxt[idx_r - 4'h1] = 1'b1;
            end
        end
    end

    // Internal conversion clock divider, runs only while converting
    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            div_r <= 7'h00;
        end else if (state_r != adcsc_pkg::ST_INT_CONV || int_step) begin
            div_r <= 7'h00;
        end else begin
            div_r <= div_r + 7'h01;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Conversion sequencer, strobe and sample register
    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            state_r    <= adcsc_pkg::ST_IDLE;
            cmd_r      <= adcsc_pkg::CMD_RST;
            strb_r     <= 1'b1;
            sar_r      <= 10'h000;
            idx_r      <= 4'hf;
            step_cnt_r <= 4'h0;
        end else if (hold_ev) begin
            cmd_r      <= rx_cmd;
            sar_r      <= adcsc_pkg::SAR_FIRST;
            idx_r      <= adcsc_pkg::MSB_IDX;
            step_cnt_r <= 4'h0;
            unique case (rx_cmd.clk_power_mode)
                adcsc_pkg::MODE_EXT: begin
                    state_r <= adcsc_pkg::ST_EXT_STRB;
                    strb_r  <= 1'b1;
                end
                adcsc_pkg::MODE_INT: begin
                    state_r <= adcsc_pkg::ST_INT_CONV;
                    strb_r  <= 1'b0;
                end
                adcsc_pkg::MODE_PDOWN,
                adcsc_pkg::MODE_UNASG: begin
                    state_r <= adcsc_pkg::ST_IDLE;
                    strb_r  <= 1'b0;
                end
            endcase
        end else if (cs_rise && cmd_r.clk_power_mode ==
                     adcsc_pkg::MODE_EXT) begin
            state_r <= adcsc_pkg::ST_IDLE;
            strb_r  <= 1'b0;
        end else begin
            unique case (state_r)
                adcsc_pkg::ST_IDLE: ;
                adcsc_pkg::ST_EXT_STRB,
                adcsc_pkg::ST_EXT_CONV,
                adcsc_pkg::ST_INT_CONV: begin
                    if (step_ev) begin
                        sar_r      <= sar_nxt;
                        idx_r      <= idx_r - 4'h1;
                        step_cnt_r <= step_cnt_r + 4'h1;
                        if (state_r == adcsc_pkg::ST_EXT_STRB) begin
                            state_r <= adcsc_pkg::ST_EXT_CONV;
                            strb_r  <= 1'b0;
                        end else if (conv_done) begin
                            state_r <= adcsc_pkg::ST_IDLE;
                        end else if (state_r == adcsc_pkg::ST_INT_CONV
                                     && idx_r == 4'h0) begin
                            state_r <= adcsc_pkg::ST_INT_PUSH;
                        end
                    end
                end
                adcsc_pkg::ST_INT_PUSH: begin
                    // Waits here while the result FIFO is full
                    if (fifo_in_ready) begin
                        state_r <= adcsc_pkg::ST_IDLE;
                        strb_r  <= 1'b1;
                    end
                end
                default: state_r <= adcsc_pkg::ST_IDLE;
            endcase
        end
    end

    // Track and hold switch and input routing
    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            track_r <= 1'b1;
            mux_r   <= '0;
        end else if (hold_ev) begin
            track_r <= 1'b0;
            mux_r   <= chan_map(rx_cmd.chan_pick,
                                rx_cmd.input_config_select);
        end else if (sclk_fall && cs_act &&
                     rx_cnt_r == adcsc_pkg::TRACK_BIT_NUM) begin
            track_r <= 1'b1;
            mux_r   <= chan_map(rx_sh_r[3:1], 1'b1);
        end else if (conv_done) begin
            track_r <= 1'b1;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Result buffer between the sequencer and the read shifter
    adcsc_fifo #(
        .WIDTH (adcsc_pkg::RES_W),
        .DEPTH (adcsc_pkg::FIFO_DEPTH)
    ) u_fifo (
        .clk_in        (clk_in),
        .rst_in        (rst_in),
        .in_valid_in   (state_r == adcsc_pkg::ST_INT_PUSH),
        .in_data_in    (res),
        .in_ready_out  (fifo_in_ready),
        .out_valid_out (fifo_out_valid),
        .out_data_out  (fifo_out_data),
        .out_ready_in  (pop)
    );
    assign pop = (sh_cnt_r == 4'h0) && !sclk_fall;

    // Read shifter and data pin, moved only on falling edges
    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            sh_r     <= 12'h000;
            sh_cnt_r <= 4'h0;
            dout_r   <= 1'b0;
        end else if (pop && fifo_out_valid) begin
            sh_r     <= {fifo_out_data, 2'h0};
            sh_cnt_r <= 4'(adcsc_pkg::OUT_BITS);
        end else if (sclk_fall && cs_act) begin
            if (step_ev && state_r != adcsc_pkg::ST_INT_CONV) begin
                dout_r <= dec_out;
            end else begin
                dout_r   <= sh_r[11];
                sh_r     <= {sh_r[10:0], 1'b0};
                sh_cnt_r <= (sh_cnt_r == 4'h0) ? 4'h0 :
                            sh_cnt_r - 4'h1;
            end
        end
    end

    // Pin drivers; enables are low while driving
    assign dout_out                   = dout_r;
    assign dout_oe_n_out              = !cs_act;
    assign conversion_strobe_out      = strb_r;
    assign conversion_strobe_oe_n_out = !cs_act &&
        cmd_r.clk_power_mode == adcsc_pkg::MODE_EXT;
    assign dac_code_out   = sar_r;
    assign mux_out        = mux_r;
    assign track_out      = track_r;
    assign unipolar_out   = cmd_r.polarity_select;
    assign power_down_out = cmd_r.clk_power_mode == adcsc_pkg::MODE_PDOWN;

    ////////////////////////////////////////////////////////////////////
    // Checks

    a_dout_tristate: assert property (!cs_act |-> dout_oe_n_out)
        else $error("data pin driven while deselected");
    a_dout_fall_only: assert property (
        $changed(dout_r) |-> $past(sclk_fall))
        else $error("data pin moved without a falling edge");
    a_rx_cs_gate: assert property (
        !cs_act |=> rx_cnt_r == 4'h0 && $stable(rx_sh_r))
        else $error("command shifted while deselected");
    a_rx_zero_skip: assert property (
        sclk_rise && cs_act && rx_cnt_r == 4'h0 && !din_s
        |=> rx_cnt_r == 4'h0)
        else $error("leading zero taken as start");
    a_rx_capture: assert property (
        sclk_rise && cs_act && rx_cnt_r != 4'h0 &&
        rx_cnt_r < adcsc_pkg::HOLD_BIT_NUM
        |=> rx_sh_r[0] == $past(din_s))
        else $error("command bit not captured on rise");
    a_track_open: assert property (
        sclk_fall && cs_act && rx_cnt_r == adcsc_pkg::TRACK_BIT_NUM
        |=> track_out)
        else $error("sampler not tracking after fifth bit");
    a_hold_close: assert property (hold_ev |=> !track_out)
        else $error("sampler not holding after last bit");
    a_int_strobe: assert property (
        state_r == adcsc_pkg::ST_INT_CONV |-> !conversion_strobe_out)
        else $error("strobe high during internal conversion");
    a_ext_pulse: assert property (
        hold_ev && rx_cmd.clk_power_mode == adcsc_pkg::MODE_EXT
        |=> conversion_strobe_out &&
            state_r == adcsc_pkg::ST_EXT_STRB)
        else $error("external strobe pulse missing");
    a_ext_pulse_end: assert property (
        state_r == adcsc_pkg::ST_EXT_STRB && step_ev
        |=> !conversion_strobe_out)
        else $error("external strobe longer than one period");
    a_strobe_tristate: assert property (
        !cs_act && cmd_r.clk_power_mode == adcsc_pkg::MODE_EXT
        |-> conversion_strobe_oe_n_out)
        else $error("strobe driven while deselected");
    a_ext_step_sclk: assert property (
        state_r == adcsc_pkg::ST_EXT_CONV && !sclk_fall
        |=> $stable(step_cnt_r))
        else $error("external step without serial clock");
    a_reconnect: assert property (conv_done |=> track_out)
        else $error("sampler not reconnected after conversion");

    c_ext_done: cover property (state_r == adcsc_pkg::ST_EXT_CONV
                                && conv_done);
    c_int_push: cover property (state_r == adcsc_pkg::ST_INT_PUSH
                                && fifo_in_ready);
    c_fifo_stall: cover property (state_r == adcsc_pkg::ST_INT_PUSH
                                  && !fifo_in_ready);
    c_restart: cover property (restart_r && hold_ev);
endmodule

// ---- test/adcsc_master.sv ----
// Serial master model driving clock mode zero byte transfers
`timescale 1ns/100ps
module adcsc_master (
    // Clock
    input  wire logic clk_in,
    // Serial pins
    output logic      sclk_out,
    output logic      cs_n_out,
    output logic      din_out,
    input  wire logic dout_in
);
    ////////////////////////////////////////////////////////////////////
    // Idle clock low, chip deselected
    initial begin
        sclk_out = 1'b0;
        cs_n_out = 1'b1;
        din_out = 1'b0;
    end
    // Chip select change, then settle past the pin filter
    task sel(input logic v);
        cs_n_out <= v;
        repeat (5) @(negedge clk_in);
    endtask
    // One byte MSB first; data set on the fall, taken at the rise
    task xfer(input logic [7:0] tx, output logic [7:0] rx);
        for (int i = 7; i >= 0; i--) begin
            din_out <= tx[i];
            repeat (5) @(negedge clk_in);
            rx[i] = dout_in;
            sclk_out <= 1'b1;
            repeat (5) @(negedge clk_in);
            sclk_out <= 1'b0;
        end
    endtask
endmodule

// ---- test/tb_adcsc_top.sv ----
// Self-checking bench of the converter serial control block
`timescale 1ns/100ps
module tb_adcsc_top;
    logic                  clk_in, rst_in, sclk, cs_n, din, dout, doe_n;
    logic                  strb, soe_n, track, uni, pdn;
    logic [9:0]            dac, tgt, ta;
    logic [7:0]            r1, r2, r3;
    adcsc_pkg::adcsc_mux_t mux;
    int                    failures = 0;
    int                    compares = 0;
    typedef struct packed {
        logic [7:0] cmd;
        logic [9:0] tgt;
        logic [8:0] mux;
    } adcsc_row_t;
    adcsc_row_t rows [8] = '{
        '{8'h9f, 10'h3ff, 9'h021}, '{8'hd7, 10'h000, 9'h041},
        '{8'haf, 10'h155, 9'h081}, '{8'hef, 10'h2aa, 9'h101},
        '{8'h9b, 10'h200, 9'h024}, '{8'ha3, 10'h1ff, 9'h090},
        '{8'hdb, 10'h001, 9'h042}, '{8'heb, 10'h3fe, 9'h108}};
    ////////////////////////////////////////////////////////////////////
    // Clock and the design under test
    initial begin
        clk_in = 1'b0;
        forever #4 clk_in = ~clk_in;
    end
    adcsc_top dut_u (.clk_in(clk_in), .rst_in(rst_in), .sclk_in(sclk),
        .cs_n_in(cs_n), .din_in(din), .dout_out(dout),
        .dout_oe_n_out(doe_n), .conversion_strobe_out(strb),
        .conversion_strobe_oe_n_out(soe_n), .comp_in(dac <= tgt),
        .dac_code_out(dac), .mux_out(mux), .track_out(track),
        .unipolar_out(uni), .power_down_out(pdn));
    // A released data pin reads back inverted, so stale bits show up
    adcsc_master m_u (.clk_in(clk_in), .sclk_out(sclk),
        .cs_n_out(cs_n), .din_out(din),
        .dout_in(doe_n ? !dout : dout));
    ////////////////////////////////////////////////////////////////////
    // Compare, count and report
    task chk(input string nm, input logic [15:0] seen, exp);
        compares++;
        if (seen !== exp) begin
            failures++;
            $display("CHECK FAILED %s exp %h seen %h", nm, exp, seen);
        end
    endtask
    task end_sim;
        $display("compares %0d failures %0d", compares, failures);
        if (failures == 0 && compares > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask
    // Watchdog, a few times the expected run
    initial begin
        repeat (20000) @(posedge clk_in);
        failures++;
        end_sim;
    end
    ////////////////////////////////////////////////////////////////////
    // Reset and deselect first, then rows, mid conversion reset, internal mode and buffer cases
    initial begin
        rst_in = 1'b1;
        tgt    = 10'h0;
        ta     = 10'h0;
        repeat (2) @(negedge clk_in);
        rst_in = 1'b0;
        repeat (5) @(negedge clk_in);
        chk("rst", 16'({doe_n, strb, soe_n, track}), 16'hd);
        // Bits sent while deselected must not start a conversion
        m_u.xfer(8'hfe, r1);
        repeat (5) @(negedge clk_in);
        chk("desel", 16'(strb), 16'h1);
        foreach (rows[i]) begin
            tgt = rows[i].tgt;
            m_u.sel(1'b0);
            m_u.xfer(8'h00, r1);
            m_u.xfer(rows[i].cmd, r1);
            repeat (5) @(negedge clk_in);
            chk("strb_hi", 16'(strb), 16'h1);
            chk("mux", 16'(mux), 16'(rows[i].mux));
            chk("mode", 16'({track, uni, pdn}),
                16'({rows[i].cmd[3], 1'b0}));
            m_u.xfer(8'h00, r2);
            chk("strb_lo", 16'(strb), 16'h0);
            m_u.xfer(8'h00, r3);
            m_u.sel(1'b1);
            // Bipolar results come out two's complement
            chk("res", {r2, r3}, {1'b0, rows[i].tgt ^ (rows[i].cmd[3] ?
                10'h0 : 10'h200), 5'h0});
            chk("tri", 16'({doe_n, soe_n, track}), 16'h7);
        end
        // Reset in mid conversion with the select still low
        m_u.sel(1'b0);
        m_u.xfer(8'h9f, r1);
        repeat (5) @(negedge clk_in);
        chk("pre_rst", 16'(strb), 16'h1);
        rst_in = 1'b1;
        repeat (2) @(negedge clk_in);
        rst_in = 1'b0;
        repeat (5) @(negedge clk_in);
        chk("mid_rst", 16'({doe_n, strb, soe_n, track, dac}),
            16'h1400);
        m_u.sel(1'b1);
        // Internal mode converts on its own clock
        tgt = 10'h2c3;
        m_u.sel(1'b0);
        m_u.xfer(8'hae, r1);
        repeat (5) @(negedge clk_in);
        chk("int_lo", 16'(strb), 16'h0);
        for (int n = 0; n < 2000 && strb !== 1'b1; n++)
            @(negedge clk_in);
        m_u.xfer(8'h00, r2);
        m_u.xfer(8'h00, r3);
        chk("int_res", 16'({r2[6:0], r3[7:5]}), 16'(tgt));
        m_u.xfer(8'h9c, r1);
        repeat (5) @(negedge clk_in);
        chk("pdown", 16'(pdn), 16'h1);
        m_u.sel(1'b1);
        // A second result waits in the buffer while the first shifts out
        ta  = 10'h1a5;
        tgt = ta;
        m_u.sel(1'b0);
        m_u.xfer(8'hae, r1);
        repeat (5) @(negedge clk_in);
        for (int n = 0; n < 2000 && strb !== 1'b1; n++)
            @(negedge clk_in);
        tgt = 10'h0f3;
        m_u.xfer(8'ha6, r1);
        chk("buf_head", 16'(r1), 16'({1'b0, ta[9:3]}));
        repeat (5) @(negedge clk_in);
        for (int n = 0; n < 2000 && strb !== 1'b1; n++)
            @(negedge clk_in);
        m_u.xfer(8'h00, r2);
        m_u.xfer(8'h00, r3);
        // First tail, two pad zeros, then the bipolar second result
        chk("buf_order", {r2, r3},
            {ta[2:0], 2'h0, tgt ^ 10'h200, 1'b0});
        m_u.xfer(8'h00, r1);
        chk("buf_empty", 16'(r1), 16'h0);
        m_u.sel(1'b1);
        end_sim;
    end
endmodule
